// [rtl/klem_monitor.v]
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "klem_regs.vh"
// Contract
// [RQ1] protection active blocks all mode changes
// [RQ2] per-level gating of display, reset, up/down
// [RQ3] underflow flagged, outputs and sub-display kept
// [RQ4] reset key or input clears range errors
// [RQ5] overflow in listed modes, flashes 1s
// [RQ6] tachometer: only reset key clears overflow
// [RQ7] cpu fault: outputs off, key clears
// [RQ8] ram fault: outputs off, power-up only
// [RQ9] nvm fault: outputs off, checksum, key restores
// [RQ10] two outputs: on-count alarm, outputs unchanged
// [RQ11] on counts kept and keep counting
// [RQ12] alarm alternates display, key suppresses code
// [RQ13] protection only with switch on, lamp lit
// [RQ14] alarm values in thousands, zero disables
// [RQ15] faults override range errors and alarm
module klem_monitor #(
  parameter BLINK_HALF = `KLEM_CLK_HZ * `KLEM_BLINK_S / 2,
  parameter CNT_W      = 32
) (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [7:0]  i_addr,         // register byte address
  input  wire [31:0] i_wdata,        // write data
  input  wire        i_wr,           // write strobe
  input  wire        i_rd,           // read strobe
  output reg  [31:0] o_rdata,        // read data, cycle after read
  input  wire        i_key_mode,     // mode change key combination
  input  wire        i_key_disp,     // display switch key
  input  wire        i_key_reset,    // reset key
  input  wire        i_key_updown,   // up/down keys
  input  wire        i_ext_reset,    // external reset input
  input  wire        i_protect_sw,   // key-protect switch
  input  wire [31:0] i_present,      // present value, signed
  input  wire        i_cpu_fault,    // processor fault detect
  input  wire        i_ram_fault,    // working memory fault detect
  input  wire        i_nvm_fault,    // non-volatile fault detect
  input  wire        i_out1_on,      // output 1 on pulse
  input  wire        i_out2_on,      // output 2 on pulse
  input  wire        i_outs_req,     // outputs wanted by counter
  output wire        o_mode_ok,      // accepted mode change key
  output wire        o_disp_ok,      // accepted display key
  output wire        o_reset_ok,     // accepted reset key
  output wire        o_updown_ok,    // accepted up/down key
  output wire        o_protect_led,  // key-protect indicator
  output reg         o_out_enable,   // outputs allowed
  output reg  [2:0]  o_main_sel,     // main display code
  output reg  [2:0]  o_sub_sel,      // sub-display code
  output reg         o_factory_restore, // restore defaults pulse
  output wire        o_irq           // level interrupt
);

  // keys are slow, so two cycles of delay cost nothing; a level
  // shorter than one clock period may be lost entirely
  // key, switch, fault and on-pulse inputs pass two flops before use; i_present and i_outs_req are used directly
  reg [10:0] sync_a;
  reg [10:0] sync_b;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync_a <= 11'h000;
      sync_b <= 11'h000;
    end else begin
      sync_a <= {i_key_mode, i_key_disp, i_key_reset, i_key_updown,
                 i_ext_reset, i_protect_sw, i_cpu_fault, i_ram_fault,
                 i_nvm_fault, i_out1_on, i_out2_on};
      sync_b <= sync_a;
    end
  end
  wire k_mode  = sync_b[10];
  wire k_disp  = sync_b[9];
  wire k_rst   = sync_b[8];
  wire k_ud    = sync_b[7];
  wire ext_rst = sync_b[6];
  wire prot_sw = sync_b[5];
  wire f_cpu   = sync_b[4];
  wire f_ram   = sync_b[3];
  wire f_nvm   = sync_b[2];
  wire on1     = sync_b[1];
  wire on2     = sync_b[0];

  // registers
  reg [31:0]        ctrl;            // level and configuration
  reg [`KLEM_EV_W-1:0] status;       // sticky events
  reg [`KLEM_EV_W-1:0] mask;         // interrupt mask
  reg [13:0]        alarm1;          // alarm value 1, thousands
  reg [13:0]        alarm2;          // alarm value 2, thousands
  reg [CNT_W-1:0]   count1;          // on count output 1
  reg [CNT_W-1:0]   count2;          // on count output 2
  reg               on1_d;           // edge detect of output 1
  reg               on2_d;           // edge detect of output 2
  reg               err_under;
  reg               err_over;
  reg               err_cpu;
  reg               err_ram;
  reg               err_nvm;
  reg               alarm_ack;       // code suppressed after key
  reg [31:0]        blink_cnt;
  reg               blink;

  wire [2:0] lvl    = ctrl[`KLEM_CTRL_LVL_MSB:`KLEM_CTRL_LVL_LSB];
  wire       sixdig = ctrl[`KLEM_CTRL_SIXDIG];
  wire       tacho  = ctrl[`KLEM_CTRL_TACHO];
  wire       ovmode = ctrl[`KLEM_CTRL_OVMODE];
  wire       twoout = ctrl[`KLEM_CTRL_TWOOUT];

  // gating table per level; bits {disp, reset, updown}
  function [2:0] key_allow;
    input [2:0] level;
    begin
      case (level)
        `KLEM_LVL_TWO:   key_allow = 3'h5;
        `KLEM_LVL_THREE: key_allow = 3'h6;
        `KLEM_LVL_FOUR:  key_allow = 3'h4;
        `KLEM_LVL_FIVE:  key_allow = 3'h0;
        `KLEM_LVL_SIX:   key_allow = 3'h3;
        `KLEM_LVL_SEVEN: key_allow = 3'h1;
        default:         key_allow = 3'h7; // level one and unused 0
      endcase
    end
  endfunction

  // protection applies only with the switch on
  wire [2:0] allow = prot_sw ? key_allow(lvl) : 3'h7;          // [RQ13] [RQ2]
  assign o_protect_led = prot_sw;                               // [RQ13]
  assign o_mode_ok     = k_mode & ~prot_sw;                     // [RQ1]
  assign o_disp_ok     = k_disp & allow[2];                     // [RQ2]
  assign o_reset_ok    = k_rst  & allow[1];                     // [RQ2]
  assign o_updown_ok   = k_ud   & allow[0];                     // [RQ2]

  // one press acts once: edge of the accepted reset key
  reg  rst_key_d;
  wire rst_key_edge = o_reset_ok & ~rst_key_d;

  // range detection, signed compare
  wire signed [31:0] pv = i_present;
  wire signed [31:0] lo = sixdig ? `KLEM_UNDER6 : `KLEM_UNDER4;
  wire signed [31:0] hi = sixdig ? `KLEM_OVER6 : `KLEM_OVER4;
  wire under_now = pv < lo;                                     // [RQ3]
  wire over_now  = (ovmode | tacho) & (pv > hi);                // [RQ5]
  // external reset does not clear overflow in tachometer mode
  wire clr_under = rst_key_edge | ext_rst;                      // [RQ4]
  wire clr_over  = rst_key_edge | (ext_rst & ~tacho);           // [RQ6]

  // alarm thresholds in thousands; zero disables
  wire [CNT_W-1:0] lim1 = alarm1 * `KLEM_ALARM_UNIT;            // [RQ14]
  wire [CNT_W-1:0] lim2 = alarm2 * `KLEM_ALARM_UNIT;
  wire exc1 = (alarm1 != 14'h0000) & (count1 > lim1);           // [RQ14]
  wire exc2 = (alarm2 != 14'h0000) & (count2 > lim2);
  wire ocnt_now = twoout & (exc1 | exc2);                       // [RQ10]

  // error latches; a detection in a clear cycle wins
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      err_under <= 1'b0;
      err_over  <= 1'b0;
      err_cpu   <= 1'b0;
      err_ram   <= 1'b0;
      err_nvm   <= 1'b0;
      alarm_ack <= 1'b0;
      rst_key_d <= 1'b0;
      o_factory_restore <= 1'b0;
    end else begin
      rst_key_d <= o_reset_ok;
      err_under <= under_now | (err_under & ~clr_under);        // [RQ4]
      err_over  <= over_now  | (err_over  & ~clr_over);         // [RQ6]
      err_cpu   <= f_cpu | (err_cpu & ~rst_key_edge);           // [RQ7]
      err_ram   <= f_ram | err_ram;                             // [RQ8]
      err_nvm   <= f_nvm | (err_nvm & ~rst_key_edge);           // [RQ9]
      o_factory_restore <= err_nvm & ~f_nvm & rst_key_edge;     // [RQ9]
      // acknowledge holds until the alarm goes away
      if (!ocnt_now)
        alarm_ack <= 1'b0;
      else if (rst_key_edge)
        alarm_ack <= 1'b1;                                      // [RQ12]
    end
  end

  // counting the rising edge keeps a long on-time to one count
  // on counts: never cleared by the reset key
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      count1 <= {CNT_W{1'b0}};
      count2 <= {CNT_W{1'b0}};
      on1_d  <= 1'b0;
      on2_d  <= 1'b0;
    end else begin
      on1_d <= on1;
      on2_d <= on2;
      // saturate so the count cannot wrap past the alarm
      if (on1 & ~on1_d & ~&count1)
        count1 <= count1 + 1'b1;                                // [RQ11]
      if (on2 & ~on2_d & ~&count2)
        count2 <= count2 + 1'b1;                                // [RQ11]
    end
  end

  // free running, so the first flash after an error may be short
  // 1 s flash cycle: toggle every half period
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF - 1) begin
      blink_cnt <= 32'h0;
      blink     <= ~blink;                                      // [RQ5]
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // display and output selection, fixed priority
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_out_enable <= 1'b0;
      o_main_sel   <= `KLEM_DISP_NORMAL;
      o_sub_sel    <= `KLEM_DISP_NORMAL;
    end else if (err_ram) begin                                 // [RQ15]
      o_out_enable <= 1'b0;                                     // [RQ8]
      o_main_sel   <= `KLEM_DISP_MEM;
      o_sub_sel    <= `KLEM_DISP_BLANK;
    end else if (err_cpu) begin
      o_out_enable <= 1'b0;                                     // [RQ7]
      o_main_sel   <= `KLEM_DISP_CPU;
      o_sub_sel    <= `KLEM_DISP_BLANK;
    end else if (err_nvm) begin
      o_out_enable <= 1'b0;                                     // [RQ9]
      o_main_sel   <= `KLEM_DISP_MEM;
      o_sub_sel    <= `KLEM_DISP_CHECKSUM;
    end else begin
      // range errors and alarm leave outputs and sub-display alone
      o_out_enable <= i_outs_req;                               // [RQ3] [RQ10]
      o_sub_sel    <= `KLEM_DISP_NORMAL;
      if (err_over)
        o_main_sel <= blink ? `KLEM_DISP_OVER : `KLEM_DISP_BLANK;
      else if (err_under)
        o_main_sel <= blink ? `KLEM_DISP_UNDER : `KLEM_DISP_BLANK;
      else if (ocnt_now & ~alarm_ack & blink)
        o_main_sel <= `KLEM_DISP_OCNT;                          // [RQ12]
      else
        o_main_sel <= `KLEM_DISP_NORMAL;
    end
  end

  // event vector for sticky status
  wire [`KLEM_EV_W-1:0] ev;
  assign ev[`KLEM_EV_UNDER] = err_under;
  assign ev[`KLEM_EV_OVER]  = err_over;
  assign ev[`KLEM_EV_CPU]   = err_cpu;
  assign ev[`KLEM_EV_RAM]   = err_ram;
  assign ev[`KLEM_EV_NVM]   = err_nvm;
  assign ev[`KLEM_EV_OCNT]  = ocnt_now;

  // ctrl bit 3 is reserved and always reads zero
  // register writes; a set beats a write-one clear
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl   <= `KLEM_CTRL_RESET;
      status <= {`KLEM_EV_W{1'b0}};
      mask   <= {`KLEM_EV_W{1'b0}};
      alarm1 <= 14'h0000;
      alarm2 <= 14'h0000;
    end else begin
      if (i_wr && i_addr == `KLEM_ADDR_CTRL)
        ctrl <= i_wdata & 32'h0000_00F7;
      if (i_wr && i_addr == `KLEM_ADDR_MASK)
        mask <= i_wdata[`KLEM_EV_W-1:0];
      if (i_wr && i_addr == `KLEM_ADDR_ALARM1)
        alarm1 <= i_wdata[13:0];
      if (i_wr && i_addr == `KLEM_ADDR_ALARM2)
        alarm2 <= i_wdata[13:0];
      if (i_wr && i_addr == `KLEM_ADDR_STATUS)
        status <= (status & ~i_wdata[`KLEM_EV_W-1:0]) | ev;
      else
        status <= status | ev;
    end
  end

  assign o_irq = |(status & mask);

  // read port, data one cycle later; unmapped reads zero
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `KLEM_ADDR_CTRL:     o_rdata <= ctrl;
        `KLEM_ADDR_STATUS:   o_rdata <= {26'h0, status};
        `KLEM_ADDR_MASK:     o_rdata <= {26'h0, mask};
        `KLEM_ADDR_ERRSTATE: o_rdata <= {26'h0, ev};
        `KLEM_ADDR_ALARM1:   o_rdata <= {18'h0, alarm1};
        `KLEM_ADDR_ALARM2:   o_rdata <= {18'h0, alarm2};
        `KLEM_ADDR_COUNT1:   o_rdata <= count1;
        `KLEM_ADDR_COUNT2:   o_rdata <= count2;
        default:             o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

endmodule

// [rtl/klem_regs.vh]
`ifndef KLEM_REGS_VH
`define KLEM_REGS_VH
// register word offsets (byte addresses, one aligned word each)
`define KLEM_ADDR_CTRL      8'h00
`define KLEM_ADDR_STATUS    8'h04
`define KLEM_ADDR_MASK      8'h08
`define KLEM_ADDR_ERRSTATE  8'h0C
`define KLEM_ADDR_ALARM1    8'h10
`define KLEM_ADDR_ALARM2    8'h14
`define KLEM_ADDR_COUNT1    8'h18
`define KLEM_ADDR_COUNT2    8'h1C
// ctrl fields
`define KLEM_CTRL_LVL_LSB   0
`define KLEM_CTRL_LVL_MSB   2
`define KLEM_CTRL_SIXDIG    4
`define KLEM_CTRL_TACHO     5
`define KLEM_CTRL_OVMODE    6
`define KLEM_CTRL_TWOOUT    7
`define KLEM_CTRL_RESET     32'h0000_0090
// event bits (status and mask)
`define KLEM_EV_UNDER       0
`define KLEM_EV_OVER        1
`define KLEM_EV_CPU         2
`define KLEM_EV_RAM         3
`define KLEM_EV_NVM         4
`define KLEM_EV_OCNT        5
`define KLEM_EV_W           6
// key protect levels
`define KLEM_LVL_ONE        3'h1
`define KLEM_LVL_TWO        3'h2
`define KLEM_LVL_THREE      3'h3
`define KLEM_LVL_FOUR       3'h4
`define KLEM_LVL_FIVE       3'h5
`define KLEM_LVL_SIX        3'h6
`define KLEM_LVL_SEVEN      3'h7
// range limits
`define KLEM_UNDER6         32'hFFFE_7961
`define KLEM_UNDER4         32'hFFFF_FC19
`define KLEM_OVER6          32'h000F_423F
`define KLEM_OVER4          32'h0000_270F
// alarm unit and timing
`define KLEM_ALARM_UNIT     32'h0000_03E8
`define KLEM_CLK_HZ         32'h017D_7840
`define KLEM_BLINK_S        32'h0000_0001
// display selection codes
`define KLEM_DISP_NORMAL    3'h0
`define KLEM_DISP_UNDER     3'h1
`define KLEM_DISP_OVER      3'h2
`define KLEM_DISP_CPU       3'h3
`define KLEM_DISP_MEM       3'h4
`define KLEM_DISP_CHECKSUM  3'h5
`define KLEM_DISP_OCNT      3'h6
`define KLEM_DISP_BLANK     3'h7
`endif

// [verif/klem_chk_monitor.sv]
`timescale 1ns/1ps
`include "klem_regs.vh"
// watches the lockout and error outputs at the block's ports
module klem_chk_monitor (
  input wire       i_ref_clk,
  input wire       i_rst,
  input wire       i_key_disp,
  input wire       i_key_reset,
  input wire       i_key_updown,
  input wire       i_protect_sw,
  input wire       i_outs_req,
  input wire       o_mode_ok,
  input wire       o_disp_ok,
  input wire       o_reset_ok,
  input wire       o_updown_ok,
  input wire       o_protect_led,
  input wire       o_out_enable,
  input wire [2:0] o_main_sel,
  input wire [2:0] o_sub_sel,
  input wire       o_factory_restore
);
  // reset history: the key synchronisers need two edges to flush
  reg  [2:0] rh = 3'h7;
  wire       cpu = o_main_sel == `KLEM_DISP_CPU;
  wire       mem = o_main_sel == `KLEM_DISP_MEM;
  wire       blank = o_sub_sel == `KLEM_DISP_BLANK;
  always @(posedge i_ref_clk) rh <= {rh[1:0], i_rst};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || (|rh));
  a_mode_locked: assert property (
    o_protect_led |-> !o_mode_ok)
    else $error("mode key accepted under protection");
  a_key_cause: assert property (
    (!o_disp_ok || $past(i_key_disp, 2)) &&
    (!o_reset_ok || $past(i_key_reset, 2)) &&
    (!o_updown_ok || $past(i_key_updown, 2)))
    else $error("key accepted without a press");
  a_led_follow: assert property (
    o_protect_led == $past(i_protect_sw, 2))
    else $error("protect lamp does not follow switch");
  a_fault_off: assert property (
    (cpu || mem) [*2] |-> !o_out_enable)
    else $error("outputs on during a fault");
  a_ram_sticky: assert property (
    mem && blank |=> mem && blank)
    else $error("memory fault left without power-up");
  a_cpu_blank: assert property (
    cpu |-> blank)
    else $error("sub display lit during cpu fault");
  a_nvm_sum: assert property (
    o_sub_sel == `KLEM_DISP_CHECKSUM |-> mem && !o_out_enable)
    else $error("checksum shown without memory fault");
  a_restore_once: assert property (
    o_factory_restore |=> !o_factory_restore)
    else $error("restore pulse longer than a cycle");
  a_under_keep: assert property (
    o_main_sel == `KLEM_DISP_UNDER && $stable(i_outs_req)
      |-> o_out_enable == i_outs_req)
    else $error("outputs changed by underflow");
endmodule
bind klem_monitor klem_chk_monitor klem_chk_monitor_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_key_disp(i_key_disp),
  .i_key_reset(i_key_reset), .i_key_updown(i_key_updown),
  .i_protect_sw(i_protect_sw), .i_outs_req(i_outs_req),
  .o_mode_ok(o_mode_ok), .o_disp_ok(o_disp_ok), .o_reset_ok(o_reset_ok),
  .o_updown_ok(o_updown_ok), .o_protect_led(o_protect_led),
  .o_out_enable(o_out_enable), .o_main_sel(o_main_sel),
  .o_sub_sel(o_sub_sel), .o_factory_restore(o_factory_restore));

// [verif/klem_keys.sv]
`timescale 1ns/1ps
// operator keys and external reset line
module klem_keys (
  input  wire       i_ref_clk,
  output reg  [4:0] o_key      // mode, disp, reset, updown, ext reset
);
  initial o_key = 5'h00;
  // a press lasts n edges: shorter taps slip past the synchronisers
  task press(input [4:0] k, input integer n);
    begin
      @(posedge i_ref_clk) o_key <= k;
      repeat (n) @(posedge i_ref_clk);
      o_key <= 5'h00;
    end
  endtask
endmodule

// [verif/klem_monitor_tb.sv]
`timescale 1ns/1ps
`include "klem_regs.vh"
module klem_monitor_tb;
  localparam [2:0]  d_norm = `KLEM_DISP_NORMAL;
  localparam [2:0]  d_mem  = `KLEM_DISP_MEM;
  localparam [2:0]  d_off  = `KLEM_DISP_BLANK;
  localparam [2:0]  d_und  = `KLEM_DISP_UNDER;
  localparam [2:0]  d_cpu  = `KLEM_DISP_CPU;
  // accepted disp, reset, updown per level, level one in the low bits
  localparam [20:0] gate = 21'h0589AF;
  reg         i_ref_clk = 0, i_rst = 1, wr = 0, rd = 0, rd_d = 0, sw = 0;
  reg         req = 1, cpu = 0, ram = 0, nvm = 0, o1 = 0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0, present = 32'h0;
  reg  [31:0] expq[$];    // expected read data, oldest first
  wire [31:0] rdata;
  wire [4:0]  key;
  wire [2:0]  msel, ssel;
  wire        mode_ok, disp_ok, reset_ok, updown_ok, led, oen, restore, irq;
  integer     failures = 0, n_compared = 0, seed = 55, n_restore = 0, i, hit;
  always #20 i_ref_clk = ~i_ref_clk;
  klem_keys klem_keys_i (.i_ref_clk(i_ref_clk), .o_key(key));
  // out2 follows out1 with a zero alarm value: it must never alarm
  klem_monitor #(.BLINK_HALF(4)) klem_monitor_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_key_mode(key[4]),
    .i_key_disp(key[3]), .i_key_reset(key[2]), .i_key_updown(key[1]),
    .i_ext_reset(key[0]), .i_protect_sw(sw), .i_present(present),
    .i_cpu_fault(cpu), .i_ram_fault(ram), .i_nvm_fault(nvm),
    .i_out1_on(o1), .i_out2_on(o1), .i_outs_req(req),
    .o_mode_ok(mode_ok), .o_disp_ok(disp_ok), .o_reset_ok(reset_ok),
    .o_updown_ok(updown_ok), .o_protect_led(led), .o_out_enable(oen),
    .o_main_sel(msel), .o_sub_sel(ssel), .o_factory_restore(restore),
    .o_irq(irq));
  task automatic check(input [31:0] seen, input [31:0] exp,
                       input [63:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      if (failures == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // wait n edges, then step past the edge so outputs have settled
  task tick(input integer n);
    begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask
  // one bus cycle; a read notes its expected data for the watcher
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_ref_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w) expq.push_back(d);
      @(posedge i_ref_clk);
      wr <= 0;
      rd <= 0;
    end
  endtask
  task wait_main(input [2:0] c);
    begin
      hit = 0;
      while (msel !== c && hit < 40) begin
        tick(1);
        hit = hit + 1;
      end
      // a code that never shows is a failure, not a silent pass
      if (hit >= 40) failures = failures + 1;
    end
  endtask
  // count the cycles showing code c over n cycles
  task scan(input [2:0] c, input integer n);
    begin
      hit = 0;
      repeat (n) begin
        tick(1);
        if (msel === c) hit = hit + 1;
      end
    end
  endtask
  // hold all four keys and compare the acceptance pattern
  task keys(input [4:0] exp);
    fork
      klem_keys_i.press(5'h1E, 5);
      begin
        tick(4);
        check({mode_ok, disp_ok, reset_ok, updown_ok, led}, exp, "keys");
      end
    join
  endtask
  // read data stand only in the cycle after the read strobe
  always @(posedge i_ref_clk) begin
    rd_d <= rd;
    if (restore === 1'b1) n_restore <= n_restore + 1;
    if (rd_d) check(rdata, expq.pop_front(), "rdata");
  end
  initial begin
    #(40 * 20000);
    failures = failures + 1;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 0;
    present <= $random(seed) % 900;
    bus(0, `KLEM_ADDR_CTRL, 32'h90);
    bus(0, 8'h20, 32'h0);
    sw <= 1;
    for (i = 1; i < 8; i = i + 1) begin
      bus(1, `KLEM_ADDR_CTRL, 32'h90 | i);
      keys({1'b0, gate[3 * i - 3 +: 3], 1'b1});
    end
    sw <= 0;
    keys(5'h1E);
    bus(1, `KLEM_ADDR_CTRL, 32'h91);
    present <= `KLEM_UNDER6 - 1;
    wait_main(`KLEM_DISP_UNDER);
    check({msel, ssel, oen}, {d_und, d_norm, 1'b1}, "under");
    present <= 0;
    klem_keys_i.press(5'h01, 5);
    tick(2);
    check(msel, d_norm, "extclr");
    bus(1, `KLEM_ADDR_CTRL, 32'hB1);
    present <= `KLEM_OVER6 + 1;
    wait_main(`KLEM_DISP_OVER);
    scan(d_off, 12);
    check(hit != 0, 1, "flash");
    present <= 0;
    klem_keys_i.press(5'h01, 5);
    scan(d_norm, 12);
    check(hit, 0, "tacho");
    klem_keys_i.press(5'h04, 5);
    tick(2);
    check(msel, d_norm, "keyclr");
    // four-digit limits with the overflow output mode, no tachometer
    bus(1, `KLEM_ADDR_CTRL, 32'h41);
    present <= `KLEM_OVER4 + 1;
    wait_main(`KLEM_DISP_OVER);
    check(oen, 1, "over4");
    present <= `KLEM_UNDER4 - 1;
    klem_keys_i.press(5'h01, 5);
    wait_main(d_und);
    check({msel, ssel, oen}, {d_und, d_norm, 1'b1}, "under4");
    present <= 0;
    klem_keys_i.press(5'h01, 5);
    tick(2);
    check(msel, d_norm, "rngclr");
    bus(0, `KLEM_ADDR_STATUS, 32'h3);
    bus(1, `KLEM_ADDR_STATUS, 32'h3F);
    bus(0, `KLEM_ADDR_STATUS, 32'h0);
    bus(1, `KLEM_ADDR_CTRL, 32'h91);
    present <= `KLEM_UNDER6 - 1;
    cpu <= 1;
    wait_main(`KLEM_DISP_CPU);
    cpu <= 0;
    tick(3);
    check({msel, ssel, oen}, {d_cpu, d_off, 1'b0}, "cpu");
    present <= 0;
    klem_keys_i.press(5'h04, 5);
    tick(2);
    check(msel, d_norm, "cpuclr");
    nvm <= 1;
    wait_main(d_mem);
    nvm <= 0;
    tick(3);
    check({ssel, oen}, {`KLEM_DISP_CHECKSUM, 1'b0}, "nvm");
    klem_keys_i.press(5'h04, 5);
    tick(2);
    check({msel, n_restore[3:0]}, {d_norm, 4'h1}, "restore");
    bus(1, `KLEM_ADDR_MASK, 32'h20);
    bus(1, `KLEM_ADDR_ALARM1, 32'h1);
    for (i = 0; i < 1001; i = i + 1) begin
      if (i == 1000) check(irq, 0, "atlimit");
      o1 <= 1;
      tick(3);
      o1 <= 0;
      tick(3);
    end
    check(irq, 1, "irq");
    wait_main(`KLEM_DISP_OCNT);
    check({msel, oen}, {`KLEM_DISP_OCNT, 1'b1}, "alarm");
    scan(d_norm, 8);
    check(hit != 0, 1, "altern");
    klem_keys_i.press(5'h04, 5);
    scan(`KLEM_DISP_OCNT, 20);
    check(hit, 0, "ack");
    bus(0, `KLEM_ADDR_COUNT1, 32'h3E9);
    bus(0, `KLEM_ADDR_COUNT2, 32'h3E9);
    bus(1, `KLEM_ADDR_MASK, 32'h0);
    tick(1);
    check(irq, 0, "masked");
    ram <= 1;
    wait_main(d_mem);
    ram <= 0;
    klem_keys_i.press(5'h04, 5);
    tick(2);
    check({msel, ssel, oen}, {d_mem, d_off, 1'b0}, "ram");
    // only a fresh power-up leaves the memory fault
    i_rst <= 1;
    tick(2);
    i_rst <= 0;
    tick(3);
    check({msel, ssel, oen}, {d_norm, d_norm, 1'b1}, "powerup");
    complete_run;
  end
endmodule
